// ### core/addr_attr_dev.sv
// Function
// - Address phase carries three odd parity bits.
// - Parity 0 covers address 0-31, 1 covers 32-63.
// - Parity 2 covers type, size code, unit select.
// - Attributes and parity switch with the address.
// - Snooped even parity causes checkstop or machine check.
// - Tag always sits at address bits 8-15.
// - Five shared lines carry the transfer type.
// - Write-flush, write-kill/clean, control-out codes fixed.
// - Snooper maps reserved type codes to Null.
// - Unit select high: size code counts bytes.
// - Unit select low: size code counts beats.
// - Each beat is sixteen bytes.
// - Master drives address the cycle after grant.
// - Master releases one cycle after start negates.
`timescale 1ns/1ps
`default_nettype none
module addr_attr_dev
  import addr_attr_pkg::*;
(
  input wire logic CLK,
  input wire logic RST,
  addr_bus_if.dev bus,
  input wire logic MST_REQ,
  input wire addr_t MST_ADDR,
  input wire tag_t MST_TAG,
  input wire ttype_t MST_TYPE,
  input wire tsize_t MST_SIZE,
  input wire logic MST_UNIT,
  input wire logic PAR_CHECK_EN,
  input wire logic MCHK_EN,
  output logic MST_BUSY,
  output logic MST_DONE,
  output logic SNOOP_VALID,
  output addr_t SNOOP_ADDR,
  output tag_t SNOOP_TAG,
  output ttype_t SNOOP_TYPE,
  output tsize_t SNOOP_SIZE,
  output logic SNOOP_UNIT,
  output len_t SNOOP_BYTES,
  output apar_t PAR_ERR,
  output logic MACHINE_CHECK,
  output logic CHECKSTOP
);

  typedef struct packed {
    dev_state_t state;
    logic req;
    logic oe;
    logic seen_ets;
    logic ets_q;
    logic busy;
    logic done;
    addr_t addr;
    ttype_t ttype;
    tsize_t tsize;
    logic unit;
    logic snp_valid;
    addr_t snp_addr;
    ttype_t snp_type;
    tsize_t snp_size;
    logic snp_unit;
    len_t snp_len;
    apar_t par_err;
    logic mchk;
    logic chkstop;
  } dev_st_t;

  localparam dev_st_t DEV_RESET = '{state: DEV_STATE_RST, default: '0};

  dev_st_t st_q;
  dev_st_t st_d;
  apar_t snoop_par;
  apar_t snoop_err;

  // Parity on the snooped phase, compared against the received bits.
  assign snoop_par = calc_par(bus.addr, bus.transfer_type_code,
                              bus.transfer_size_code, bus.size_unit_select);
  assign snoop_err = snoop_par ^ bus.addr_parity_bits;

  always_comb
  begin
    st_d = st_q;
    st_d.done = 1'b0;
    st_d.snp_valid = 1'b0;
    st_d.par_err = '0;
    st_d.mchk = 1'b0;
    // Start is kept one cycle, since others' phases are sampled the cycle after it.
    st_d.ets_q = bus.early_transfer_start;

    case (st_q.state)
      D_IDLE:
      begin
        // A checkstopped part no longer masters the bus.
        if (MST_REQ && !st_q.chkstop)
        begin
          st_d.state = D_WAIT;
          st_d.req = 1'b1;
          st_d.addr = MST_ADDR;
          st_d.addr[TAG_FIRST:TAG_LAST] = MST_TAG;
          st_d.ttype = MST_TYPE;
          st_d.tsize = MST_SIZE;
          st_d.unit = MST_UNIT;
        end
      end
      D_WAIT:
      begin
        if (bus.addr_grant_pulse)
        begin
          st_d.state = D_DRIVE;
          st_d.req = 1'b0;
          st_d.oe = 1'b1;
          // Start may come with the grant; the tenure then lasts one cycle only.
          st_d.seen_ets = bus.early_transfer_start;
        end
      end
      D_DRIVE:
      begin
        if (bus.early_transfer_start)
        begin
          st_d.seen_ets = 1'b1;
        end
        else if (st_q.seen_ets)
        begin
          // Start was high and is now low, so the drivers let go at this edge.
          st_d.oe = 1'b0;
          st_d.seen_ets = 1'b0;
          st_d.state = D_IDLE;
          st_d.done = 1'b1;
        end
      end
      default:
      begin
        st_d = DEV_RESET;
      end
    endcase

    // Busy follows the next state, so it falls in the cycle of the done pulse.
    st_d.busy = (st_d.state != D_IDLE);

    // Others' phases are valid one cycle after start was sampled high; our own are skipped.
    if (st_q.ets_q && !st_q.oe)
    begin
      st_d.snp_valid = 1'b1;
      st_d.snp_addr = bus.addr;
      st_d.snp_type = is_reserved(bus.transfer_type_code) ? TT_NULL
                      : bus.transfer_type_code;
      st_d.snp_size = bus.transfer_size_code;
      st_d.snp_unit = bus.size_unit_select;
      st_d.snp_len = xfer_bytes(bus.transfer_size_code,
                                bus.size_unit_select);
      // A stopped part reports no further parity faults, so PAR_ERR shows the fault that stopped it for one cycle and then stays clear.
      if (PAR_CHECK_EN && (snoop_err != '0) && !st_q.chkstop)
      begin
        st_d.par_err = snoop_err;
        // With machine checks masked the error is fatal, so the part stops.
        if (MCHK_EN)
        begin
          st_d.mchk = 1'b1;
        end
        else
        begin
          st_d.chkstop = 1'b1;
        end
      end
    end
  end

  // Reset puts every field to its idle value, the sticky stop included.
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      st_q <= DEV_RESET;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign bus.addr_request = st_q.req;
  assign bus.dev_oe = st_q.oe;
  assign bus.dev_addr = st_q.addr;
  assign bus.dev_transfer_type_code = st_q.ttype;
  assign bus.dev_transfer_size_code = st_q.tsize;
  assign bus.dev_size_unit_select = st_q.unit;
  // Parity comes only from flops, so it settles with the bits it covers.
  assign bus.dev_addr_parity_bits = calc_par(st_q.addr, st_q.ttype,
                                             st_q.tsize, st_q.unit);

  assign MST_BUSY = st_q.busy;
  assign MST_DONE = st_q.done;
  assign SNOOP_VALID = st_q.snp_valid;
  assign SNOOP_ADDR = st_q.snp_addr;
  assign SNOOP_TAG = st_q.snp_addr[TAG_FIRST:TAG_LAST];
  assign SNOOP_TYPE = st_q.snp_type;
  assign SNOOP_SIZE = st_q.snp_size;
  assign SNOOP_UNIT = st_q.snp_unit;
  assign SNOOP_BYTES = st_q.snp_len;
  assign PAR_ERR = st_q.par_err;
  assign MACHINE_CHECK = st_q.mchk;
  assign CHECKSTOP = st_q.chkstop;

endmodule : addr_attr_dev
`default_nettype wire

// ### core/addr_attr_pkg.sv
`default_nettype none
package addr_attr_pkg;

  localparam int ADDR_W = 64;
  localparam int TYPE_W = 5;
  localparam int SIZE_W = 4;
  localparam int PAR_W = 3;
  localparam int TAG_W = 8;
  localparam int LEN_W = 9;

  // Big-endian numbering: bit 0 is the most significant bit on every field except the byte count len_t.
  localparam int TAG_FIRST = 8;
  localparam int TAG_LAST = 15;
  localparam int PAR0_FIRST = 0;
  localparam int PAR0_LAST = 31;
  localparam int PAR1_FIRST = 32;
  localparam int PAR1_LAST = 63;

  typedef logic [0:ADDR_W-1] addr_t;
  typedef logic [0:TYPE_W-1] ttype_t;
  typedef logic [0:SIZE_W-1] tsize_t;
  typedef logic [0:PAR_W-1] apar_t;
  typedef logic [0:TAG_W-1] tag_t;
  typedef logic [LEN_W-1:0] len_t;

  // Transfer type codes; an A-variant code has the leading bit free.
  localparam ttype_t TT_CLEAN = 5'h00;
  localparam ttype_t TT_LOAD_RESERVE = 5'h01;
  localparam ttype_t TT_WR_FLUSH = 5'h02;
  localparam ttype_t TT_DATA_CLAIM = 5'h03;
  localparam ttype_t TT_FLUSH = 5'h04;
  localparam ttype_t TT_WR_KILL_CLEAN = 5'h06;
  localparam ttype_t TT_SYNC = 5'h08;
  localparam ttype_t TT_XLATE_SYNC = 5'h09;
  localparam ttype_t TT_READ = 5'h0A;
  localparam ttype_t TT_DATA_INVAL = 5'h0C;
  localparam ttype_t TT_INSTR_INVAL = 5'h0D;
  localparam ttype_t TT_READ_OWN = 5'h0E;
  localparam ttype_t TT_IO_BARRIER = 5'h10;
  localparam ttype_t TT_PROG_IO = 5'h11;
  localparam ttype_t TT_EXT_CTRL_OUT = 5'h14;
  localparam ttype_t TT_PROG_IO_REPLY = 5'h15;
  localparam ttype_t TT_XLATE_INVAL = 5'h18;
  localparam ttype_t TT_EXT_CTRL_IN = 5'h1C;
  localparam ttype_t TT_RERUN = 5'h1D;
  localparam ttype_t TT_NULL = 5'h1F;

  localparam len_t BEAT_BYTES = 9'h010;
  localparam len_t ZERO_CODE_COUNT = 9'h010;

  // Value of a released line; the board pulls the bus high.
  localparam logic BUS_FLOAT = 1'b1;

  typedef enum logic [1:0] {D_IDLE = 2'b00, D_WAIT = 2'b01, D_DRIVE = 2'b11} dev_state_t;
  typedef enum logic [2:0] {
    H_IDLE = 3'b000, H_GRANT = 3'b001, H_ETS = 3'b011, H_TAIL = 3'b010,
    H_OWN_A = 3'b110, H_OWN_B = 3'b111
  } host_state_t;

  localparam dev_state_t DEV_STATE_RST = D_IDLE;
  localparam host_state_t HOST_STATE_RST = H_IDLE;

  function automatic apar_t calc_par(addr_t a, ttype_t t, tsize_t s, logic u);
    apar_t p;
    p[0] = ~^a[PAR0_FIRST:PAR0_LAST];
    p[1] = ~^a[PAR1_FIRST:PAR1_LAST];
    p[2] = ~^{t, s, u};
    return p;
  endfunction : calc_par

  function automatic logic is_reserved(ttype_t t);
    logic r;
    r = 1'b0;
    case (t)
      5'h05, 5'h07, 5'h0B, 5'h0F, 5'h16, 5'h17, 5'h19, 5'h1B: r = 1'b1;
      default: r = 1'b0;
    endcase
    return r;
  endfunction : is_reserved

  function automatic len_t xfer_bytes(tsize_t s, logic unit_bytes);
    len_t n;
    n = (s == 4'h0) ? ZERO_CODE_COUNT : len_t'(s);
    return unit_bytes ? n : len_t'(n * BEAT_BYTES);
  endfunction : xfer_bytes

endpackage : addr_attr_pkg
`default_nettype wire

// ### core/addr_bus_if.sv
`timescale 1ns/1ps
`default_nettype none
interface addr_bus_if;
  import addr_attr_pkg::*;

  logic addr_request;
  logic addr_grant_pulse;
  logic early_transfer_start;

  addr_t dev_addr;
  ttype_t dev_transfer_type_code;
  tsize_t dev_transfer_size_code;
  logic dev_size_unit_select;
  apar_t dev_addr_parity_bits;
  logic dev_oe;

  addr_t host_addr;
  ttype_t host_transfer_type_code;
  tsize_t host_transfer_size_code;
  logic host_size_unit_select;
  apar_t host_addr_parity_bits;
  logic host_oe;

  addr_t addr;
  ttype_t transfer_type_code;
  tsize_t transfer_size_code;
  logic size_unit_select;
  apar_t addr_parity_bits;

  assign addr = dev_oe ? dev_addr : host_oe ? host_addr : {ADDR_W{BUS_FLOAT}};
  assign transfer_type_code = dev_oe ? dev_transfer_type_code :
                              host_oe ? host_transfer_type_code : {TYPE_W{BUS_FLOAT}};
  assign transfer_size_code = dev_oe ? dev_transfer_size_code :
                              host_oe ? host_transfer_size_code : {SIZE_W{BUS_FLOAT}};
  assign size_unit_select = dev_oe ? dev_size_unit_select :
                            host_oe ? host_size_unit_select : BUS_FLOAT;
  assign addr_parity_bits = dev_oe ? dev_addr_parity_bits :
                            host_oe ? host_addr_parity_bits : {PAR_W{BUS_FLOAT}};

  modport dev (
    output addr_request, dev_addr, dev_transfer_type_code, dev_transfer_size_code,
    output dev_size_unit_select, dev_addr_parity_bits, dev_oe,
    input addr_grant_pulse, early_transfer_start,
    input addr, transfer_type_code, transfer_size_code, size_unit_select, addr_parity_bits
  );

  modport host (
    output addr_grant_pulse, early_transfer_start, host_addr, host_transfer_type_code,
    output host_transfer_size_code, host_size_unit_select, host_addr_parity_bits, host_oe,
    input addr_request,
    input addr, transfer_type_code, transfer_size_code, size_unit_select, addr_parity_bits
  );
endinterface : addr_bus_if
`default_nettype wire

// ### core/addr_attr_host.sv
`timescale 1ns/1ps
`default_nettype none
module addr_attr_host
  import addr_attr_pkg::*;
(
  input wire logic CLK,
  input wire logic RST,
  addr_bus_if.host bus,
  input wire logic OWN_REQ,
  input wire addr_t OWN_ADDR,
  input wire ttype_t OWN_TYPE,
  input wire tsize_t OWN_SIZE,
  input wire logic OWN_UNIT,
  output logic OWN_BUSY,
  output logic SEEN_VALID,
  output addr_t SEEN_ADDR,
  output ttype_t SEEN_TYPE,
  output len_t SEEN_BYTES,
  output apar_t SEEN_PAR_ERR
);

  typedef struct packed {
    host_state_t state;
    logic grant;
    logic ets;
    logic oe;
    logic busy;
    addr_t addr;
    ttype_t ttype;
    tsize_t tsize;
    logic unit;
    logic seen_valid;
    addr_t seen_addr;
    ttype_t seen_type;
    len_t seen_len;
    apar_t seen_err;
  } host_st_t;

  localparam host_st_t HOST_RESET = '{state: HOST_STATE_RST, default: '0};

  host_st_t st_q;
  host_st_t st_d;

  always_comb
  begin
    st_d = st_q;
    st_d.grant = 1'b0;
    st_d.ets = 1'b0;
    st_d.seen_valid = 1'b0;
    st_d.seen_err = '0;
    case (st_q.state)
      H_IDLE:
      begin
        // The device is served first; grants stay four cycles apart.
        if (bus.addr_request)
        begin
          st_d.state = H_GRANT;
          st_d.grant = 1'b1;
        end
        else if (OWN_REQ)
        begin
          st_d.state = H_OWN_A;
          st_d.oe = 1'b1;
          st_d.ets = 1'b1;
          st_d.addr = OWN_ADDR;
          st_d.ttype = OWN_TYPE;
          st_d.tsize = OWN_SIZE;
          st_d.unit = OWN_UNIT;
        end
      end
      H_GRANT:
      begin
        st_d.state = H_ETS;
        st_d.ets = 1'b1;
      end
      H_ETS:
      begin
        st_d.state = H_TAIL;
      end
      H_TAIL:
      begin
        st_d.state = H_IDLE;
        st_d.seen_valid = 1'b1;
        st_d.seen_addr = bus.addr;
        st_d.seen_type = is_reserved(bus.transfer_type_code) ? TT_NULL
                         : bus.transfer_type_code;
        st_d.seen_len = xfer_bytes(bus.transfer_size_code,
                                   bus.size_unit_select);
        st_d.seen_err = calc_par(bus.addr, bus.transfer_type_code, bus.transfer_size_code,
                                 bus.size_unit_select) ^ bus.addr_parity_bits;
      end
      H_OWN_A:
      begin
        st_d.state = H_OWN_B;
      end
      H_OWN_B:
      begin
        st_d.state = H_IDLE;
        st_d.oe = 1'b0;
      end
      default:
      begin
        st_d = HOST_RESET;
      end
    endcase
    st_d.busy = (st_d.state != H_IDLE);
  end

  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      st_q <= HOST_RESET;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign bus.addr_grant_pulse = st_q.grant;
  assign bus.early_transfer_start = st_q.ets;
  assign bus.host_oe = st_q.oe;
  assign bus.host_addr = st_q.addr;
  assign bus.host_transfer_type_code = st_q.ttype;
  assign bus.host_transfer_size_code = st_q.tsize;
  assign bus.host_size_unit_select = st_q.unit;
  assign bus.host_addr_parity_bits = calc_par(st_q.addr, st_q.ttype,
                                              st_q.tsize, st_q.unit);

  assign OWN_BUSY = st_q.busy;
  assign SEEN_VALID = st_q.seen_valid;
  assign SEEN_ADDR = st_q.seen_addr;
  assign SEEN_TYPE = st_q.seen_type;
  assign SEEN_BYTES = st_q.seen_len;
  assign SEEN_PAR_ERR = st_q.seen_err;

endmodule : addr_attr_host
`default_nettype wire

// ### bench/addr_attr_properties.sv
`timescale 1ns/1ps
`default_nettype none
module addr_attr_properties
  import addr_attr_pkg::*;
(
  input wire logic CLK,
  input wire logic RST,
  input wire logic addr_request,
  input wire logic addr_grant_pulse,
  input wire logic early_transfer_start,
  input wire logic dev_oe,
  input wire logic host_oe,
  input wire addr_t addr,
  input wire ttype_t transfer_type_code,
  input wire tsize_t transfer_size_code,
  input wire logic size_unit_select,
  input wire apar_t addr_parity_bits
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);
  wire drv = dev_oe || host_oe;
  sequence tenure_grant;
    addr_grant_pulse && addr_request;
  endsequence
  sequence tenure_end;
    dev_oe && $fell(early_transfer_start);
  endsequence
  par_low_a: assert property (drv |-> ^{addr[0:31], addr_parity_bits[0]})
    else $error("parity 0 even");
  par_high_a: assert property (drv |-> ^{addr[32:63], addr_parity_bits[1]})
    else $error("parity 1 even");
  par_attr_a: assert property (drv |-> ^{transfer_type_code, transfer_size_code,
    size_unit_select, addr_parity_bits[2]}) else $error("parity 2 even");
  grant_drive_a: assert property (tenure_grant |=> dev_oe)
    else $error("no drive after grant");
  drive_cause_a: assert property ($rose(dev_oe) |-> $past(addr_grant_pulse))
    else $error("drive without grant");
  drive_release_a: assert property (tenure_end |=> !dev_oe)
    else $error("late release");
  tenure_len_a: assert property ($rose(dev_oe) |-> ##[1:2] !dev_oe)
    else $error("tenure too long");
  attr_hold_a: assert property (dev_oe && $past(dev_oe) |-> $stable(addr) &&
    $stable(transfer_type_code) && $stable(transfer_size_code) && $stable(size_unit_select) &&
    $stable(addr_parity_bits)) else $error("attributes moved in tenure");
  one_driver_a: assert property (!(dev_oe && host_oe))
    else $error("both ends drive");
endmodule : addr_attr_properties
`default_nettype wire

// ### bench/addr_phase_parity_attr_test.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin num_errors++; \
  $display("Error %s expected %0h seen %0h", nm, ex, got); end end
module addr_phase_parity_attr_test;
  import addr_attr_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  int num_errors = 0;
  int n_compared = 0;
  int seed = 32'h8C45B5A6;
  logic mreq2 = 1'b0;
  int rsv[$] = '{5, 7, 11, 15, 22, 23, 25, 27};
  logic mreq = 1'b0, oreq = 1'b0, pen = 1'b1, men = 1'b1, mu = 1'b0, ou = 1'b0;
  addr_t ma = '0, oa = '0, cap_a, seen_a, sa1;
  tag_t mt = '0, stag1;
  ttype_t mty = '0, oty = '0, seen_t, st1;
  tsize_t ms = '0, os = '0, ss1;
  len_t seen_b, sb1;
  apar_t cap_p, seen_pe, pe1, pe2;
  logic seen_v, sv1, sv2, su1, mdone, mc2, cs2, mbusy, mc1, cs1, obusy, mdone2;
  addr_bus_if bus();
  addr_bus_if bus2();
  always #4 clk = ~clk;
  always @(posedge clk) if (bus.dev_oe)
  begin
    cap_a <= bus.addr;
    cap_p <= bus.addr_parity_bits;
  end
  addr_attr_dev addr_attr_dev_i (.CLK(clk), .RST(rst), .bus(bus.dev), .MST_REQ(mreq),
    .MST_ADDR(ma), .MST_TAG(mt), .MST_TYPE(mty), .MST_SIZE(ms), .MST_UNIT(mu),
    .PAR_CHECK_EN(pen), .MCHK_EN(men), .MST_BUSY(mbusy), .MST_DONE(mdone), .SNOOP_VALID(sv1),
    .SNOOP_ADDR(sa1), .SNOOP_TAG(stag1), .SNOOP_TYPE(st1), .SNOOP_SIZE(ss1), .SNOOP_UNIT(su1),
    .SNOOP_BYTES(sb1), .PAR_ERR(pe1), .MACHINE_CHECK(mc1), .CHECKSTOP(cs1));
  addr_attr_host addr_attr_host_i (.CLK(clk), .RST(rst), .bus(bus.host), .OWN_REQ(oreq),
    .OWN_ADDR(oa), .OWN_TYPE(oty), .OWN_SIZE(os), .OWN_UNIT(ou), .OWN_BUSY(obusy),
    .SEEN_VALID(seen_v), .SEEN_ADDR(seen_a), .SEEN_TYPE(seen_t), .SEEN_BYTES(seen_b),
    .SEEN_PAR_ERR(seen_pe));
  // Second device faces the bench, which breaks parity on purpose.
  addr_attr_dev addr_attr_dev_i2 (.CLK(clk), .RST(rst), .bus(bus2.dev), .MST_REQ(mreq2),
    .MST_ADDR(ma), .MST_TAG(mt), .MST_TYPE(mty), .MST_SIZE(ms), .MST_UNIT(mu),
    .PAR_CHECK_EN(pen), .MCHK_EN(men), .MST_BUSY(), .MST_DONE(mdone2), .SNOOP_VALID(sv2),
    .SNOOP_ADDR(), .SNOOP_TAG(), .SNOOP_TYPE(), .SNOOP_SIZE(), .SNOOP_UNIT(),
    .SNOOP_BYTES(), .PAR_ERR(pe2), .MACHINE_CHECK(mc2), .CHECKSTOP(cs2));
  addr_attr_properties addr_attr_properties_i (.CLK(clk), .RST(rst),
    .addr_request(bus.addr_request), .addr_grant_pulse(bus.addr_grant_pulse),
    .early_transfer_start(bus.early_transfer_start), .dev_oe(bus.dev_oe),
    .host_oe(bus.host_oe), .addr(bus.addr), .transfer_type_code(bus.transfer_type_code),
    .transfer_size_code(bus.transfer_size_code), .size_unit_select(bus.size_unit_select),
    .addr_parity_bits(bus.addr_parity_bits));
  function automatic apar_t par_m(addr_t a, ttype_t t, tsize_t s, logic u);
    return {~^a[0:31], ~^a[32:63], ~^{t, s, u}};
  endfunction : par_m
  function automatic ttype_t snoop_m(ttype_t t);
    foreach (rsv[i]) if (rsv[i] == int'(t)) return 5'h1F;
    return t;
  endfunction : snoop_m
  function automatic len_t bytes_m(tsize_t s, logic u);
    int n;
    n = (s == 4'h0) ? 16 : int'(s);
    return len_t'(u ? n : n * 16);
  endfunction : bytes_m
  task wrap_up;
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : wrap_up
  // Checks right after an edge first, since a pulse may land on the edge already passed.
  task automatic wait_hi(input int w);
    int n;
    n = 0;
    #1;
    while (n < 40 && !(w == 0 ? seen_v === 1'b1 : w == 1 ? sv1 === 1'b1 : sv2 === 1'b1))
    begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n == 40)
    begin
      num_errors++;
      $display("Error wait %0d expected pulse seen none", w);
      wrap_up();
    end
  endtask : wait_hi
  task automatic dev_xfer(input ttype_t t);
    addr_t ea;
    @(posedge clk);
    mreq <= 1'b1;
    {ma, mt, ms, mu} <= 77'({$random(seed), $random(seed), $random(seed)});
    mty <= t;
    @(posedge clk);
    mreq <= 1'b0;
    #1;
    `CHK("master busy", 1'b1, mbusy)
    wait_hi(0);
    ea = ma;
    ea[8:15] = mt;
    `CHK("seen addr", ea, seen_a)
    `CHK("seen type", mty, seen_t)
    `CHK("seen bytes", bytes_m(ms, mu), seen_b)
    `CHK("seen parity err", 3'b000, seen_pe)
    `CHK("master done", 1'b1, mdone)
    `CHK("master idle", 1'b0, mbusy)
    `CHK("bus parity", par_m(ea, mty, ms, mu), cap_p)
    `CHK("bus tag", mt, cap_a[8:15])
  endtask : dev_xfer
  task automatic own_xfer(input ttype_t t, input logic zero);
    logic [68:0] r;
    r = 69'({$random(seed), $random(seed), $random(seed)});
    if (zero)
      r[4:1] = 4'h0;
    @(posedge clk);
    oreq <= 1'b1;
    {oa, os, ou} <= r;
    oty <= t;
    @(posedge clk);
    oreq <= 1'b0;
    #1;
    `CHK("own busy", 1'b1, obusy)
    wait_hi(1);
    `CHK("own idle", 1'b0, obusy)
    `CHK("snoop addr", oa, sa1)
    `CHK("snoop tag", oa[8:15], stag1)
    `CHK("snoop type", snoop_m(oty), st1)
    `CHK("snoop bytes", bytes_m(os, ou), sb1)
    `CHK("snoop unit", ou, su1)
    `CHK("snoop parity err", 3'b000, pe1)
    `CHK("snoop size", os, ss1)
    `CHK("snoop machine check", 1'b0, mc1)
    `CHK("snoop checkstop", 1'b0, cs1)
  endtask : own_xfer
  // Start comes with the grant here, which the other end never does.
  task automatic short_xfer;
    addr_t ea;
    ea = ma;
    ea[8:15] = mt;
    @(posedge clk);
    mreq2 <= 1'b1;
    @(posedge clk);
    mreq2 <= 1'b0;
    #1;
    `CHK("short request", 1'b1, bus2.addr_request)
    @(posedge clk);
    bus2.addr_grant_pulse <= 1'b1;
    bus2.early_transfer_start <= 1'b1;
    @(posedge clk);
    bus2.addr_grant_pulse <= 1'b0;
    bus2.early_transfer_start <= 1'b0;
    #1;
    `CHK("short drive", 1'b1, bus2.dev_oe)
    `CHK("short addr", ea, bus2.addr)
    `CHK("short parity", par_m(ea, mty, ms, mu), bus2.addr_parity_bits)
    @(posedge clk);
    #1;
    `CHK("short release", 1'b0, bus2.dev_oe)
    `CHK("short done", 1'b1, mdone2)
  endtask : short_xfer
  task automatic bad_xfer(input apar_t flip, input logic p, input logic m);
    logic [73:0] r;
    logic hit;
    r = 74'({$random(seed), $random(seed), $random(seed)});
    hit = p && (flip != 3'b000);
    @(posedge clk);
    pen <= p;
    men <= m;
    {bus2.host_addr, bus2.host_transfer_type_code, bus2.host_transfer_size_code,
      bus2.host_size_unit_select} <= r;
    bus2.host_addr_parity_bits <= par_m(r[73:10], r[9:5], r[4:1], r[0]) ^ flip;
    bus2.host_oe <= 1'b1;
    bus2.early_transfer_start <= 1'b1;
    @(posedge clk);
    bus2.early_transfer_start <= 1'b0;
    @(posedge clk);
    bus2.host_oe <= 1'b0;
    wait_hi(2);
    `CHK("parity err", p ? flip : 3'b000, pe2)
    `CHK("machine check", hit && m, mc2)
    `CHK("checkstop", hit && !m, cs2)
  endtask : bad_xfer
  initial
  begin
    ttype_t t;
    ttype_t mcodes[4];
    apar_t flips[6];
    mcodes = '{TT_WR_FLUSH, 5'h12, TT_WR_KILL_CLEAN, TT_EXT_CTRL_OUT};
    flips = '{3'b100, 3'b100, 3'b010, 3'b001, 3'b000, 3'b001};
    bus2.addr_grant_pulse = 1'b0;
    bus2.early_transfer_start = 1'b0;
    bus2.host_oe = 1'b0;
    {bus2.host_addr, bus2.host_transfer_type_code, bus2.host_transfer_size_code,
      bus2.host_size_unit_select, bus2.host_addr_parity_bits} = '0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    `CHK("flush code", TT_WR_FLUSH, 5'h02)
    `CHK("kill code", TT_WR_KILL_CLEAN, 5'h06)
    `CHK("ctrl out code", TT_EXT_CTRL_OUT, 5'h14)
    for (int i = 0; i < 12; i++)
    begin
      t = $random(seed);
      dev_xfer(i < 4 ? mcodes[i] : snoop_m(t) == 5'h1F ? TT_READ : t);
    end
    $display("test device master done");
    for (int i = 0; i < 32; i++)
      own_xfer(ttype_t'(i), i < 4);
    $display("test snoop decode done");
    for (int i = 0; i < 3; i++)
      short_xfer();
    $display("test short tenure done");
    // Checkstop is sticky, so the case that reaches it runs last.
    for (int i = 0; i < 6; i++)
      bad_xfer(flips[i], i > 0, i < 5);
    $display("test parity fault done");
    wrap_up();
  end
endmodule : addr_phase_parity_attr_test
`default_nettype wire
